// [hw/nhc_host.sv]
// NAND host pin controller: turns user requests into strobed pin cycles.
// Assumes a NAND device wired to the o_ pins; i_dq and i_ready_busy are synchronous.
// Overview of operation
// R1: Host drives bus only on writes.
// R2: Command byte strobed with command select high.
// R3: Address byte strobed with address select high.
// R4: Data bytes strobed with both selects low.
// R5: Busy device ignores chip select high.
// R6: Output strobe falling edge fetches next byte.
// R7: Write protect low blocks program, erase.
// R8: Ready/busy low while operation runs.
// R9: Ready/busy is open drain, always valid.
// R10: Two column cycles, upper nibble A8-A11.
// R11: Three row cycles: page, plane, block.
// R12: Unused address bits driven low.
// R13: Extra address bytes ignored by device.
// R14: A30 selects die, low if single.
// R15: Input strobe pulsed low under chip select.
// R16: Full address five cycles, erase three.
// R17: Never both selects; low for data.
`timescale 1ns/10ps
module nhc_host
  import nhc_pkg::*;
#(
  parameter bit DUAL_DIE = 1'b0
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire nhc_pkg::nhc_op_t i_req_op,
  input wire logic [7:0] i_req_byte,
  input wire logic [11:0] i_req_col,
  input wire logic [18:0] i_req_row,
  input wire logic i_write_enable,
  input wire logic [7:0] i_dq,
  input wire logic i_ready_busy,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_device_ready,
  output logic o_cle,
  output logic o_ale,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_output_strobe_n,
  output logic o_write_protect_n,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  import nhc_pkg::*;

  typedef enum logic [2:0] {NHC_IDLE, NHC_LOW, NHC_HIGH, NHC_RLOW, NHC_RHIGH} nhc_state_t;

  // ==========================================================================
  // Address byte selection by cycle number
  function automatic logic [7:0] addr_byte(input logic [11:0] col, input logic [18:0] row,
                                          input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      3'h0: b = col[7:0];
      3'h1: b = {4'h0, col[11:8] & NHC_COL_HI_MASK}; // R10 R12
      3'h2: b = row[7:0]; // R11
      3'h3: b = row[15:8];
      3'h4: b = {5'h00, row[18:16] & NHC_ROW_TOP_MASK}; // R12 R14
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  nhc_pin_if pin_bus ();
  nhc_state_t st_q, st_d;
  nhc_op_t op_q, op_d;
  logic [NHC_CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] idx_q, idx_d;
  logic [2:0] last_q, last_d;
  logic [7:0] byte_q, byte_d;
  logic [11:0] col_q, col_d;
  logic [18:0] row_q, row_d;
  logic rd_valid_q, rd_valid_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic [7:0] bus_byte;

  assign o_req_ready = (st_q == NHC_IDLE);
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data = rd_data_q;
  assign o_device_ready = i_ready_busy; // R8 R9
  assign o_write_protect_n = i_write_enable; // R7

  // ==========================================================================
  // Byte on the bus: address ops index into the layout, else the held byte
  always_comb
  begin
    if (op_q == NHC_OP_ADDR_FULL)
      bus_byte = addr_byte(col_q, row_q, idx_q); // R16
    else if (op_q == NHC_OP_ADDR_ROW)
      bus_byte = addr_byte(col_q, row_q, idx_q + 3'h2); // R16
    else
      bus_byte = byte_q;
  end

  // ==========================================================================
  // Sequencer next state; the pin levels follow the state one cycle later
  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    last_d = last_q;
    byte_d = byte_q;
    col_d = col_q;
    row_d = row_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    unique case (st_q)
      NHC_IDLE:
      begin
        if (i_req_valid)
        begin
          op_d = i_req_op;
          byte_d = i_req_byte;
          col_d = i_req_col;
          row_d = DUAL_DIE ? i_req_row : (i_req_row & ~(19'h00001 << NHC_DIE_BIT)); // R14
          idx_d = 3'h0;
          last_d = (i_req_op == NHC_OP_ADDR_FULL) ? 3'(NHC_ADDR_CYC_FULL - 1) :
                   (i_req_op == NHC_OP_ADDR_ROW) ? 3'(NHC_ADDR_CYC_ROW - 1) : 3'h0; // R13 R16
          cnt_d = NHC_CNT_W'(NHC_STROBE_LOW_CYC - 1);
          st_d = (i_req_op == NHC_OP_READ) ? NHC_RLOW : NHC_LOW;
        end
      end
      NHC_LOW:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0)
        begin
          cnt_d = NHC_CNT_W'(NHC_STROBE_HIGH_CYC - 1);
          st_d = NHC_HIGH; // R15
        end
      end
      NHC_HIGH:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0)
        begin
          if (idx_q == last_q)
            st_d = NHC_IDLE;
          else
          begin
            idx_d = idx_q + 3'h1;
            cnt_d = NHC_CNT_W'(NHC_STROBE_LOW_CYC - 1);
            st_d = NHC_LOW;
          end
        end
      end
      NHC_RLOW:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0)
        begin
          rd_data_d = i_dq; // R6
          rd_valid_d = 1'b1;
          cnt_d = NHC_CNT_W'(NHC_STROBE_HIGH_CYC - 1);
          st_d = NHC_RHIGH;
        end
      end
      NHC_RHIGH:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == '0)
          st_d = NHC_IDLE;
      end
      default: st_d = NHC_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= NHC_IDLE;
      op_q <= NHC_OP_CMD;
      cnt_q <= '0;
      idx_q <= 3'h0;
      last_q <= 3'h0;
      byte_q <= 8'h00;
      col_q <= 12'h000;
      row_q <= 19'h00000;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      last_q <= last_d;
      byte_q <= byte_d;
      col_q <= col_d;
      row_q <= row_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ==========================================================================
  // Pin levels; selects held through both strobe phases so they straddle the rising edge
  logic wr_phase;
  assign wr_phase = (st_q == NHC_LOW) || (st_q == NHC_HIGH);
  assign pin_bus.ce_n = (st_q == NHC_IDLE); // R15
  assign pin_bus.cle = wr_phase && (op_q == NHC_OP_CMD); // R2 R17
  assign pin_bus.ale = wr_phase && ((op_q == NHC_OP_ADDR_FULL) || (op_q == NHC_OP_ADDR_ROW)); // R3 R17
  assign pin_bus.we_n = (st_q != NHC_LOW); // R4 R15
  assign pin_bus.out_strobe_n = (st_q != NHC_RLOW); // R6
  assign pin_bus.dq_oe = wr_phase; // R1
  assign pin_bus.dq_out = wr_phase ? bus_byte : 8'h00;

  nhc_pin_drv u_pin_drv (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .pin(pin_bus),
    .o_cle(o_cle),
    .o_ale(o_ale),
    .o_ce_n(o_ce_n),
    .o_we_n(o_we_n),
    .o_output_strobe_n(o_output_strobe_n),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe)
  );

  // ==========================================================================
  // Checks
  sequence s_sel_write;
    o_we_n ##1 !o_we_n;
  endsequence
  // Closing address byte of either layout; its pin value shows one edge later
  sequence s_last_addr_byte;
    pin_bus.ale && ((op_q == NHC_OP_ADDR_FULL && idx_q == 3'h4) || (op_q == NHC_OP_ADDR_ROW && idx_q == 3'h2));
  endsequence
  property p_no_dual_select;
    @(posedge i_mclk) disable iff (i_rst) !(o_cle && o_ale);
  endproperty
  a_no_dual_select: assert property (p_no_dual_select) else $error("both selects high"); // R17
  property p_strobe_under_ce;
    @(posedge i_mclk) disable iff (i_rst) !o_we_n |-> !o_ce_n && o_dq_oe;
  endproperty
  a_strobe_under_ce: assert property (p_strobe_under_ce) else $error("strobe without select"); // R15
  property p_rise_keeps_sel;
    @(posedge i_mclk) disable iff (i_rst) (!o_we_n ##1 o_we_n) |-> $stable(o_cle) && $stable(o_ale) && o_dq_oe;
  endproperty
  a_rise_keeps_sel: assert property (p_rise_keeps_sel) else $error("select moved at rising edge"); // R2
  property p_low_width;
    @(posedge i_mclk) disable iff (i_rst) s_sel_write |-> !o_we_n[*3] ##1 o_we_n;
  endproperty
  a_low_width: assert property (p_low_width) else $error("strobe low width wrong"); // R15
  property p_read_no_drive;
    @(posedge i_mclk) disable iff (i_rst) !o_output_strobe_n |-> !o_dq_oe && o_we_n;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("bus driven during read"); // R1
  property p_read_capture;
    @(posedge i_mclk) disable iff (i_rst) $fell(o_output_strobe_n) |-> ##[1:4] o_rd_valid;
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read byte not captured"); // R6
  property p_col_hi_zero;
    @(posedge i_mclk) disable iff (i_rst) (pin_bus.ale && op_q == NHC_OP_ADDR_FULL && idx_q == 3'h1)
      |=> o_dq[7:4] == 4'h0;
  endproperty
  a_col_hi_zero: assert property (p_col_hi_zero) else $error("column upper nibble not low"); // R12
  property p_last_top_zero;
    @(posedge i_mclk) disable iff (i_rst) s_last_addr_byte |=> o_dq[7:3] == 5'h00;
  endproperty
  a_last_top_zero: assert property (p_last_top_zero) else $error("fifth cycle upper bits not low"); // R12
  property p_single_die_low;
    @(posedge i_mclk) disable iff (i_rst) s_last_addr_byte |=> DUAL_DIE || !o_dq[2];
  endproperty
  a_single_die_low: assert property (p_single_die_low) else $error("die select high on single die"); // R14
  property p_cycle_count;
    @(posedge i_mclk) disable iff (i_rst) (st_q == NHC_HIGH && cnt_q == '0 && idx_q == last_q) |->
      (op_q == NHC_OP_ADDR_FULL ? idx_q == 3'h4 : op_q == NHC_OP_ADDR_ROW ? idx_q == 3'h2 : idx_q == 3'h0);
  endproperty
  a_cycle_count: assert property (p_cycle_count) else $error("wrong number of address cycles"); // R16
  property p_data_sel_low;
    @(posedge i_mclk) disable iff (i_rst) (wr_phase && op_q == NHC_OP_WRITE) |-> !pin_bus.cle && !pin_bus.ale;
  endproperty
  a_data_sel_low: assert property (p_data_sel_low) else $error("select high during data"); // R4
endmodule // nhc_host

// [hw/nhc_pin_drv.sv]
// Pin register stage: drives every NAND pin except write protect from a flip-flop.
// Assumes the sequencer computes pin levels one cycle ahead.
`timescale 1ns/10ps
module nhc_pin_drv
(
  input wire logic i_mclk,
  input wire logic i_rst,
  nhc_pin_if.pins pin,
  output logic o_cle,
  output logic o_ale,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_output_strobe_n,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  // ==========================================================================
  // Registered pins, idle deselected with strobes high
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_output_strobe_n <= 1'b1;
      o_dq <= 8'h00;
      o_dq_oe <= 1'b0;
    end
    else
    begin
      o_cle <= pin.cle;
      o_ale <= pin.ale;
      o_ce_n <= pin.ce_n;
      o_we_n <= pin.we_n;
      o_output_strobe_n <= pin.out_strobe_n;
      o_dq <= pin.dq_out;
      o_dq_oe <= pin.dq_oe;
    end
  end
endmodule // nhc_pin_drv

// [hw/nhc_pin_if.sv]
// Interface carrying the NAND pin group between the sequencer and the pin driver.
// Assumes one clock domain; tri-state resolution is done outside the design.
`timescale 1ns/10ps
interface nhc_pin_if;
  logic cle;
  logic ale;
  logic ce_n;
  logic we_n;
  logic out_strobe_n;
  logic [7:0] dq_out;
  logic dq_oe;
  modport seq (output cle, ale, ce_n, we_n, out_strobe_n, dq_out, dq_oe);
  modport pins (input cle, ale, ce_n, we_n, out_strobe_n, dq_out, dq_oe);
endinterface

// [hw/nhc_pkg.sv]
// Package for the NAND host pin controller: timing counts, address layout, opcodes.
// Assumes a 100 MHz system clock; all pin timing is counted in whole cycles.
package nhc_pkg;
  // ==========================================================================
  // Timing
  localparam int NHC_CLK_NS = 10;
  localparam int NHC_STROBE_LOW_NS = 30;
  localparam int NHC_STROBE_HIGH_NS = 20;
  localparam int NHC_STROBE_LOW_CYC = (NHC_STROBE_LOW_NS + NHC_CLK_NS - 1) / NHC_CLK_NS;
  localparam int NHC_STROBE_HIGH_CYC = (NHC_STROBE_HIGH_NS + NHC_CLK_NS - 1) / NHC_CLK_NS;
  localparam int NHC_CNT_W = 4;
  // ==========================================================================
  // Address layout
  localparam int NHC_COL_W = 12;
  localparam int NHC_ROW_W = 19;
  localparam int NHC_PAGE_LSB = 0;
  localparam int NHC_PAGE_W = 6;
  localparam int NHC_PLANE_BIT = 6;
  localparam int NHC_DIE_BIT = 18;
  localparam int NHC_ADDR_CYC_FULL = 5;
  localparam int NHC_ADDR_CYC_ROW = 3;
  localparam logic [3:0] NHC_COL_HI_MASK = 4'hF;
  localparam logic [2:0] NHC_ROW_TOP_MASK = 3'h7;
  // ==========================================================================
  // Operations requested by the user side
  typedef enum logic [2:0] {
    NHC_OP_CMD,
    NHC_OP_ADDR_FULL,
    NHC_OP_ADDR_ROW,
    NHC_OP_WRITE,
    NHC_OP_READ
  } nhc_op_t;
endpackage

// [test/nhc_host_bench.sv]
// Self-checking bench for the NAND host pin controller.
// Assumes the device model beside it; bus and ready/busy wires are resolved here.
`timescale 1ns/10ps
module nhc_host_bench;
  import nhc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req_valid = 1'b0;
  nhc_op_t i_req_op = NHC_OP_CMD;
  logic [7:0] i_req_byte = 8'h00;
  logic [11:0] i_req_col = 12'h000;
  logic [18:0] i_req_row = 19'h00000;
  logic i_write_enable = 1'b1;
  logic o_req_ready, o_rd_valid, o_device_ready, o_cle, o_ale, o_ce_n, o_we_n;
  logic o_output_strobe_n, o_write_protect_n, o_dq_oe, m_oe, m_busy;
  logic [7:0] o_rd_data, o_dq, m_dq, dq_wire, rd_byte;
  logic [7:0] dq_idle = 8'h00;
  int failures = 0;
  int comparisons = 0;
  // ==========================================================================
  // Clock, and a bus that never holds a stale value once released
  initial forever #5 i_mclk = ~i_mclk;
  // Released bus shows the inverse of the last driven byte, never an unknown
  always @(posedge i_mclk) dq_idle <= (o_dq_oe === 1'b1) ? ~o_dq : ((m_oe === 1'b1) ? ~m_dq : dq_idle);
  assign dq_wire = o_dq_oe ? o_dq : (m_oe ? m_dq : dq_idle);
  nhc_host i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
    .i_req_byte(i_req_byte), .i_req_col(i_req_col), .i_req_row(i_req_row), .i_write_enable(i_write_enable),
    .i_dq(dq_wire), .i_ready_busy(!m_busy), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_device_ready(o_device_ready), .o_cle(o_cle), .o_ale(o_ale), .o_ce_n(o_ce_n),
    .o_we_n(o_we_n), .o_output_strobe_n(o_output_strobe_n), .o_write_protect_n(o_write_protect_n),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  nhc_nand_model i_model (.i_cle(o_cle), .i_ale(o_ale), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
    .i_output_strobe_n(o_output_strobe_n), .i_write_protect_n(o_write_protect_n), .i_dq(dq_wire),
    .o_dq(m_dq), .o_dq_oe(m_oe), .o_busy(m_busy));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One request, held until taken; read data grabbed on its one-cycle pulse
  task automatic req(input nhc_op_t op, input logic [7:0] b, input logic [11:0] c, input logic [18:0] r);
    int n;
    for (n = 0; n < 50 && o_req_ready !== 1'b1; n++) @(negedge i_mclk);
    i_req_valid = 1'b1;
    i_req_op = op;
    i_req_byte = b;
    i_req_col = c;
    i_req_row = r;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    for (n = 0; n < 50; n++)
    begin
      if (o_rd_valid === 1'b1) rd_byte = o_rd_data;
      if (o_req_ready === 1'b1) break;
      @(negedge i_mclk);
    end
    check("request completion", n < 50, 1);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_full_address();
    logic [7:0] exp [0:4] = '{8'hBC, 8'h0A, 8'h34, 8'h12, 8'h01};
    req(NHC_OP_CMD, 8'h00, 12'h000, 19'h00000);
    check("command byte", i_model.cmd_last, 8'h00);
    req(NHC_OP_ADDR_FULL, 8'h00, 12'hABC, 19'h51234);
    req(NHC_OP_ADDR_ROW, 8'h00, 12'h000, 19'h7FFFF);
    for (int i = 0; i < 5; i++) check("address byte", i_model.addr_b[i], exp[i]);
    check("address count", i_model.addr_n, 8);
    req(NHC_OP_READ, 8'h00, 12'h000, 19'h00000);
    check("first read", rd_byte, 8'hE6);
    req(NHC_OP_READ, 8'h00, 12'h000, 19'h00000);
    check("second read", rd_byte, 8'hE7);
    $display("test full address and read done");
  endtask
  task automatic t_erase();
    req(NHC_OP_CMD, 8'h60, 12'h000, 19'h00000);
    req(NHC_OP_ADDR_ROW, 8'h00, 12'hFFF, 19'h23456);
    check("row count", i_model.addr_n, 3);
    check("row byte", {i_model.addr_b[0], i_model.addr_b[1], i_model.addr_b[2]}, 24'h563402);
    req(NHC_OP_CMD, 8'hD0, 12'h000, 19'h00000);
    check("busy seen", o_device_ready, 1'b0);
    repeat (40) @(negedge i_mclk);
    check("ready again", o_device_ready, 1'b1);
    $display("test erase done");
  endtask
  task automatic t_protect_and_write();
    i_write_enable = 1'b0;
    @(negedge i_mclk);
    check("write protect pin", o_write_protect_n, 1'b0);
    req(NHC_OP_CMD, 8'h10, 12'h000, 19'h00000);
    check("no busy when protected", o_device_ready, 1'b1);
    i_write_enable = 1'b1;
    req(NHC_OP_CMD, 8'h80, 12'h000, 19'h00000);
    req(NHC_OP_WRITE, 8'hC3, 12'h000, 19'h00000);
    check("write data", i_model.data_last, 8'hC3);
    check("command kept", i_model.cmd_last, 8'h80);
    $display("test protect and write done");
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (12) @(negedge i_mclk);
    i_rst = 1'b0;
    t_full_address();
    t_erase();
    t_protect_and_write();
    give_verdict();
  end
  initial
  begin
    #50000;
    failures++;
    give_verdict();
  end
endmodule // nhc_host_bench

// [test/nhc_nand_model.sv]
// Behavioural NAND device seen from its pins, for the host controller bench.
// Assumes the bench resolves the shared bus and the pulled-up ready/busy wire.
`timescale 1ns/10ps
module nhc_nand_model
#(
  parameter int BUSY_NS = 300
)
(
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_output_strobe_n,
  input wire logic i_write_protect_n,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic o_busy
);
  logic [7:0] cmd_last = 8'hFF;
  logic [7:0] data_last = 8'h00;
  logic [7:0] addr_b [0:4];
  int addr_n = 0;
  logic [11:0] col = 12'h000;
  initial o_busy = 1'b0;
  initial o_dq = 8'h00;
  // ==========================================================================
  // Input latch
  // Busy runs on its own timer and ignores chip select meanwhile
  always @(posedge i_we_n)
  begin
    if (!i_ce_n && i_cle)
    begin
      cmd_last = i_dq;
      addr_n = 0;
      if ((i_dq == 8'h10 || i_dq == 8'hD0) && i_write_protect_n)
      begin
        o_busy = 1'b1;
        o_busy <= #(BUSY_NS) 1'b0;
      end
    end
    else if (!i_ce_n && i_ale)
    begin
      if (addr_n < 5) addr_b[addr_n] = i_dq;
      addr_n = addr_n + 1;
      if (addr_n == 2) col = {addr_b[1][3:0], addr_b[0]};
    end
    else if (!i_ce_n)
      data_last = i_dq;
  end
  // ==========================================================================
  // Read path: each falling output strobe under chip select fetches and steps the column
  always @(negedge i_output_strobe_n)
  begin
    if (!i_ce_n)
    begin
      o_dq = col[7:0] ^ 8'h5A;
      col = col + 12'h001;
    end
  end
  // Bus floats when deselected or strobe idle
  assign o_dq_oe = !i_ce_n && !i_output_strobe_n;
endmodule // nhc_nand_model
